// file: include/sar_defines.svh
// offsets, field positions, reset values and masks for the serial autoneg status bank
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH

// register indexes; byte address is four times the index
`define SAR_IDX_LINK_STATUS   4'h1
`define SAR_IDX_ADVERT        4'h4
`define SAR_IDX_PARTNER       4'h5
`define SAR_IDX_CONTROL       4'h8
`define SAR_IDX_IRQ_STATUS    4'h9
`define SAR_IDX_IRQ_MASK      4'ha

// status register fields
`define SAR_ST_ANEG_DONE      5
`define SAR_ST_LINK           2

// advertisement / partner fields
`define SAR_AD_LINK           15
`define SAR_AD_ACK            14
`define SAR_AD_DUPLEX         12
`define SAR_AD_SPD_HI         11
`define SAR_AD_SPD_LO         10
`define SAR_AD_TX_PAUSE       9
`define SAR_AD_RX_PAUSE       8
`define SAR_AD_FIBER          7
`define SAR_AD_FIXED          16'h0001
`define SAR_MEDIA_PARTNER_MSK 16'hdf80

// control register fields
`define SAR_CTL_MEDIA_MODE    0
`define SAR_CTL_PAUSE_EN      1
`define SAR_CTL_MASK          16'h0003
`define SAR_CTL_RESET         16'h0002

// interrupt event bits
`define SAR_EV_LINK_DOWN      0
`define SAR_EV_LINK_UP        1
`define SAR_EV_PAGE           2
`define SAR_EV_ANEG_DONE      3
`define SAR_EV_MASK           16'h000f

`endif

// file: include/sar_pkg.sv
// types for the serial autoneg status bank
package sar_pkg;

  // resolved speed code
  typedef enum logic [1:0] {
    SAR_SPD_10   = 2'h0,
    SAR_SPD_100  = 2'h1,
    SAR_SPD_1000 = 2'h2,
    SAR_SPD_RSVD = 2'h3
  } sar_speed_t;

  // local link state that feeds the advertisement word
  typedef struct packed {
    logic       copper_link;
    logic       full_duplex;
    sar_speed_t speed;
    logic       tx_pause;
    logic       rx_pause;
    logic       fiber;
  } sar_local_t;

  // serial link events from the negotiation engine
  typedef struct packed {
    logic        link_up;
    logic        aneg_done;
    logic        page_valid;
    logic [15:0] page_word;
  } sar_link_t;

  // wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } sar_wb_req_t;

  // all state of the bank
  typedef struct packed {
    logic        link_latch;
    logic        aneg_done;
    logic        link_prev;
    logic [15:0] partner;
    logic [15:0] control;
    logic [15:0] irq_status;
    logic [15:0] irq_mask;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
    logic        irq;
  } sar_state_t;

endpackage : sar_pkg

// file: logic/sar_status_regs.sv
// serial autoneg status, advertisement and partner ability registers, wishbone slave
// Function
// (RQ1) negotiation complete bit set only on true completion
// (RQ2) link bit latches low until read
// (RQ3) host reads twice for present link
// (RQ4) system layouts apply while mode is zero
// (RQ5) advert bit 15 shows copper link
// (RQ6) advert bit 12 shows resolved duplex
// (RQ7) advert bits 11:10 encode resolved speed
// (RQ8) pause and fiber bits forced zero unless enabled
// (RQ9) acknowledge cleared on link loss, loaded from page
// (RQ10) media partner bit 15 from code word
// (RQ11) media partner bit 12 from code word
// (RQ12) media partner speed from code word bits
// (RQ13) media partner bits 9:7 from code word
// (RQ14) mode bit zero system, one media
// (RQ15) reserved bits read zero, writes ignored
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ns
`include "sar_defines.svh"

module sar_status_regs
  import sar_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_sw_rst,
  input  wire logic        i_aneg_enable,
  input  wire logic        i_aneg_bypassed,
  input  wire sar_local_t  i_local,
  input  wire sar_link_t   i_link,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_wb_err,
  output logic             o_irq,
  output logic             o_media_mode
);

  sar_state_t  st;
  sar_state_t  next_st;
  sar_wb_req_t req;
  logic        access;
  logic [3:0]  idx;
  logic        mapped;
  logic        media;
  logic        pause_en;
  logic [15:0] advert;
  logic [15:0] status_word;
  logic [15:0] partner_view;
  logic [15:0] rd_word;
  logic [15:0] events;
  logic [15:0] wr_lo;
  logic        link_fall;
  logic        link_rise;

  // bundle the bus inputs for decoding
  assign req    = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, sel: i_wb_sel, adr: i_wb_adr, dat: i_wb_dat};
  // one access per strobe; ack or err drops the cycle after it is given,
  // so a refused request still standing at that edge is not taken twice
  assign access = req.cyc & req.stb & ~st.ack & ~st.err;
  assign idx    = req.adr[5:2];
  assign wr_lo  = {req.sel[1] ? req.dat[15:8] : 8'h00, req.sel[0] ? req.dat[7:0] : 8'h00};

  // mode and pause enable come from the control register
  assign media    = st.control[`SAR_CTL_MEDIA_MODE]; // RQ14
  assign pause_en = st.control[`SAR_CTL_PAUSE_EN];

  // advertisement word follows the local resolution live
  always_comb begin
    advert                  = `SAR_AD_FIXED; // RQ15
    advert[`SAR_AD_LINK]    = i_local.copper_link; // RQ5
    advert[`SAR_AD_DUPLEX]  = i_local.full_duplex; // RQ6
    advert[`SAR_AD_SPD_HI]  = i_local.speed[1]; // RQ7
    advert[`SAR_AD_SPD_LO]  = i_local.speed[0]; // RQ7
    advert[`SAR_AD_TX_PAUSE] = pause_en & i_local.tx_pause; // RQ8
    advert[`SAR_AD_RX_PAUSE] = pause_en & i_local.rx_pause; // RQ8
    advert[`SAR_AD_FIBER]    = pause_en & i_local.fiber; // RQ8
  end

  // status word: only the two live bits, reserved bits zero
  always_comb begin
    status_word                     = 16'h0000; // RQ15
    status_word[`SAR_ST_ANEG_DONE]  = st.aneg_done;
    status_word[`SAR_ST_LINK]       = st.link_latch; // RQ2
  end

  // system layout exposes only the acknowledge bit
  assign partner_view = media ? (st.partner & `SAR_MEDIA_PARTNER_MSK)
                              : (st.partner & (16'h0001 << `SAR_AD_ACK)); // RQ4

  // register mux; unmapped indexes answer with err
  always_comb begin
    rd_word = 16'h0000;
    mapped  = 1'b1;
    unique case (idx)
      `SAR_IDX_LINK_STATUS: rd_word = status_word;
      `SAR_IDX_ADVERT:      rd_word = media ? 16'h0000 : advert; // RQ4
      `SAR_IDX_PARTNER:     rd_word = partner_view;
      `SAR_IDX_CONTROL:     rd_word = st.control;
      `SAR_IDX_IRQ_STATUS:  rd_word = st.irq_status;
      `SAR_IDX_IRQ_MASK:    rd_word = st.irq_mask;
      default:              mapped  = 1'b0;
    endcase
  end

  assign link_fall = st.link_prev & ~i_link.link_up;
  assign link_rise = ~st.link_prev & i_link.link_up;

  // event vector for the sticky interrupt bits
  always_comb begin
    events                     = 16'h0000;
    events[`SAR_EV_LINK_DOWN]  = link_fall;
    events[`SAR_EV_LINK_UP]    = link_rise;
    events[`SAR_EV_PAGE]       = i_link.page_valid & i_link.link_up;
    events[`SAR_EV_ANEG_DONE]  = i_link.aneg_done & i_aneg_enable & ~i_aneg_bypassed & ~st.aneg_done;
  end

  // next state of the whole bank
  always_comb begin
    next_st           = st;
    next_st.link_prev = i_link.link_up;
    next_st.ack       = access;
    next_st.err       = 1'b0;

    // latch low: a read of the status word re-arms it to the live level
    if (access & ~req.we & mapped & (idx == `SAR_IDX_LINK_STATUS)) begin
      next_st.link_latch = i_link.link_up; // RQ2
    end
    // a drop always wins over the re-arm so no loss is missed
    if (~i_link.link_up) begin
      next_st.link_latch = 1'b0; // RQ2
    end

    // completion only from real negotiation, never from bypass or disabled
    next_st.aneg_done = i_link.link_up & i_aneg_enable & ~i_aneg_bypassed
                        & (st.aneg_done | i_link.aneg_done); // RQ1

    // partner word: cleared on link loss, loaded on base page
    if (~i_link.link_up) begin
      next_st.partner = 16'h0000; // RQ9
    end else if (i_link.page_valid) begin
      next_st.partner[`SAR_AD_ACK]     = i_link.page_word[`SAR_AD_ACK]; // RQ9
      next_st.partner[`SAR_AD_LINK]    = i_link.page_word[`SAR_AD_LINK]; // RQ10
      next_st.partner[`SAR_AD_DUPLEX]  = i_link.page_word[`SAR_AD_DUPLEX]; // RQ11
      next_st.partner[`SAR_AD_SPD_HI]  = i_link.page_word[`SAR_AD_SPD_HI]; // RQ12
      next_st.partner[`SAR_AD_SPD_LO]  = i_link.page_word[`SAR_AD_SPD_LO]; // RQ12
      // partners without enhanced negotiation send zeros here
      next_st.partner[`SAR_AD_TX_PAUSE] = i_link.page_word[`SAR_AD_TX_PAUSE]; // RQ13
      next_st.partner[`SAR_AD_RX_PAUSE] = i_link.page_word[`SAR_AD_RX_PAUSE]; // RQ13
      next_st.partner[`SAR_AD_FIBER]    = i_link.page_word[`SAR_AD_FIBER]; // RQ13
    end

    // writes land only on the writable control and interrupt registers
    if (access & req.we & mapped) begin
      unique case (idx)
        `SAR_IDX_CONTROL:    next_st.control  = wr_lo & `SAR_CTL_MASK;
        `SAR_IDX_IRQ_STATUS: next_st.irq_status = st.irq_status & ~wr_lo;
        `SAR_IDX_IRQ_MASK:   next_st.irq_mask = wr_lo & `SAR_EV_MASK;
        default:             next_st.control  = st.control; // RQ15
      endcase
    end
    // set beats the write-one clear in the same cycle
    next_st.irq_status = next_st.irq_status | events;

    // read data registered with the ack
    next_st.rdata = {16'h0000, rd_word};
    if (access & ~mapped) begin
      next_st.err   = 1'b1;
      next_st.ack   = 1'b0;
      next_st.rdata = 32'h0000_0000;
    end
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);

    // software reset clears link latch, completion and partner word but keeps configuration and the sticky interrupt status
    if (i_sw_rst) begin
      next_st.link_latch = 1'b0;
      next_st.aneg_done  = 1'b0;
      next_st.partner    = 16'h0000;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st         <= '0;
      st.control <= `SAR_CTL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_wb_dat     = st.rdata;
  assign o_wb_ack     = st.ack;
  assign o_wb_err     = st.err;
  assign o_irq        = st.irq;
  assign o_media_mode = media;

endmodule : sar_status_regs

// file: verification/sar_status_regs_monitor.sv
// assertion checker for the serial autoneg status bank
`timescale 1ns/1ns
`include "sar_defines.svh"
module sar_status_regs_monitor
  import sar_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_aneg_enable,
  input wire logic        i_aneg_bypassed,
  input wire sar_local_t  i_local,
  input wire sar_link_t   i_link,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [31:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        o_wb_err,
  input wire logic        o_media_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // a read taken at this edge; writes excluded since their data is not defined
  sequence s_rd(logic [3:0] idx);
    i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && !o_wb_err && i_wb_adr[5:2] == idx;
  endsequence
  // a base page followed by two quiet cycles with link held
  sequence s_page;
    i_link.page_valid && i_link.link_up ##1 (i_link.link_up && !i_link.page_valid)[*2];
  endsequence
  property p_ack; s_rd(4'h4) |=> o_wb_ack && !o_wb_err; endproperty
  a_ack: assert property (p_ack) else $error("mapped read not acked next cycle");
  property p_err; s_rd(4'h0) |=> o_wb_err && !o_wb_ack; endproperty
  a_err: assert property (p_err) else $error("unmapped read not refused");
  property p_stat_rsvd; s_rd(4'h1) |=> (o_wb_dat & 32'hffffffdb) == 32'h0; endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status reserved bits set");
  property p_link_low; !i_link.link_up ##1 s_rd(4'h1) |=> !o_wb_dat[2]; endproperty
  a_link_low: assert property (p_link_low) else $error("link bit read high after a drop");
  property p_aneg; (i_aneg_bypassed || !i_aneg_enable)[*2] ##0 s_rd(4'h1) |=> !o_wb_dat[5]; endproperty
  a_aneg: assert property (p_aneg) else $error("completion shown without negotiation");
  property p_adv;
    !o_media_mode && $stable(i_local) ##0 s_rd(4'h4) |=> o_wb_dat[15:10] ==
      {$past(i_local.copper_link), 2'b00, $past(i_local.full_duplex), $past(i_local.speed)};
  endproperty
  a_adv: assert property (p_adv) else $error("advert link, duplex or speed wrong");
  property p_page;
    s_page ##0 s_rd(4'h5) |=> o_wb_dat[15:0] == ($past(i_link.page_word, 3) &
      ($past(o_media_mode) ? `SAR_MEDIA_PARTNER_MSK : 16'h4000));
  endproperty
  a_page: assert property (p_page) else $error("partner word not loaded from page");
  property p_clr; (!i_link.link_up)[*2] ##0 s_rd(4'h5) |=> o_wb_dat[15:0] == 16'h0; endproperty
  a_clr: assert property (p_clr) else $error("partner word kept after link loss");
endmodule : sar_status_regs_monitor

bind sar_status_regs sar_status_regs_monitor i_mon (.i_clk, .i_sys_rst, .i_aneg_enable, .i_aneg_bypassed,
  .i_local, .i_link, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .o_wb_err, .o_media_mode);

// file: verification/sar_link_partner.sv
// link partner model: link level, completion and base pages
`timescale 1ns/1ns
module sar_link_partner
  import sar_pkg::*;
(
  input  wire logic i_clk,
  output sar_link_t o_link
);
  // link starts down
  initial o_link = '0;
  // level change just after an edge
  task automatic set_link(input logic up, input logic done);
    @(posedge i_clk);
    o_link.link_up   <= up;
    o_link.aneg_done <= done;
  endtask : set_link
  // one-cycle page; the word is inverted afterwards so stale data never looks valid
  task automatic send(input logic [15:0] w);
    @(posedge i_clk);
    o_link.page_valid <= 1'b1;
    o_link.page_word  <= w;
    @(posedge i_clk);
    o_link.page_valid <= 1'b0;
    o_link.page_word  <= ~w;
  endtask : send
endmodule : sar_link_partner

// file: verification/tb_top.sv
// self-checking bench for the serial autoneg status bank
`timescale 1ns/1ns
module tb_top
  import sar_pkg::*;
;
  logic        clk, rst, byp, en, ack, err, irq, mmode, e;
  logic [31:0] rdat, q;
  sar_local_t  loc;
  sar_link_t   lnk;
  sar_wb_req_t rq;
  int          n_mismatch, num_checks;
  // advert rows: local state beside the word it should give
  logic [6:0]  row_in[4]  = '{7'h6a, 7'h0a, 7'h41, 7'h3e};
  logic [15:0] row_exp[4] = '{16'h9501, 16'h0501, 16'h8081, 16'h1f01};
  sar_status_regs i_sar_status_regs (.i_clk(clk), .i_sys_rst(rst), .i_sw_rst(1'b0), .i_aneg_enable(en),
    .i_aneg_bypassed(byp), .i_local(loc), .i_link(lnk), .i_wb_cyc(rq.cyc), .i_wb_stb(rq.stb), .i_wb_we(rq.we),
    .i_wb_sel(rq.sel), .i_wb_adr(rq.adr), .i_wb_dat(rq.dat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
    .o_irq(irq), .o_media_mode(mmode));
  sar_link_partner i_sar_link_partner (.i_clk(clk), .o_link(lnk));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // classic cycle; the request stands until ack or err is sampled
  task automatic wb(input logic w, input logic [3:0] i, input logic [15:0] d);
    @(posedge clk);
    rq <= '{1'b1, 1'b1, w, 4'h3, {26'h0, i, 2'h0}, {16'h0, d}};
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    rq <= '0;
  endtask : wb
  task automatic rd(input logic [3:0] i, input logic [15:0] x);
    wb(1'b0, i, 16'h0);
    chk(q, {16'h0, x});
  endtask : rd
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // watchdog: the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    en = 1'b1;
    byp = 1'b0;
    loc = '0;
    rq = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(4'h1, 16'h0);
    rd(4'h8, 16'h2);
    for (int k = 0; k < 4; k++) begin
      loc <= sar_local_t'(row_in[k]);
      rd(4'h4, row_exp[k]);
    end
    $display("advert rows done");
    // pause enable off forces bits 9:7 low; write to a read-only word is dropped
    wb(1'b1, 4'h8, 16'h0);
    wb(1'b1, 4'h4, 16'hffff);
    rd(4'h4, 16'h1c01);
    wb(1'b1, 4'h8, 16'h2);
    wb(1'b0, 4'h0, 16'h0);
    chk({31'h0, e}, 32'h1);
    // link up: first read still latched low, second read live
    i_sar_link_partner.set_link(1'b1, 1'b1);
    rd(4'h1, 16'h0020);
    rd(4'h1, 16'h0024);
    i_sar_link_partner.set_link(1'b0, 1'b0);
    i_sar_link_partner.set_link(1'b1, 1'b1);
    rd(4'h1, 16'h0020);
    byp <= 1'b1;
    rd(4'h1, 16'h0004);
    byp <= 1'b0;
    $display("link status done");
    // partner word in system mode, then media mode
    i_sar_link_partner.send(16'hdfff);
    rd(4'h5, 16'h4000);
    wb(1'b1, 4'h8, 16'h3);
    chk({31'h0, mmode}, 32'h1);
    rd(4'h4, 16'h0);
    i_sar_link_partner.send(16'hffff);
    rd(4'h5, 16'hdf80);
    i_sar_link_partner.send(16'h2a55);
    rd(4'h5, 16'h0a00);
    i_sar_link_partner.set_link(1'b0, 1'b0);
    rd(4'h5, 16'h0);
    $display("partner done");
    // events are sticky; the mask gates the interrupt line
    rd(4'h9, 16'h000f);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 4'ha, 16'h0001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 4'h9, 16'h000f);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(4'h9, 16'h0);
    $display("interrupts done");
    results();
  end
endmodule : tb_top
